// ---- rtl/recorder_pkg.sv ----
// Shared constants, register map and carrier types for the disturbance recorder.
// Assumes a single 250 MHz core clock and a 50 Hz power system.
package recorder_pkg;

    // Clock and sampling rate
    localparam int CORE_CLK_HZ       = 250_000_000;
    localparam int GRID_HZ           = 50;
    localparam int SAMPLES_PER_CYCLE = 32;
    localparam int DEF_SAMPLE_DIV    = CORE_CLK_HZ / (GRID_HZ * SAMPLES_PER_CYCLE);
    localparam int DIV_W             = 18;

    // Storage and record length, times in seconds
    localparam int STORE_SEC   = 120;
    localparam int MAX_REC_SEC = 15;
    localparam int STORE_DEPTH = STORE_SEC * GRID_HZ * SAMPLES_PER_CYCLE;
    localparam int ADDR_W      = 18;
    localparam int LEN_W       = 15;
    localparam logic [LEN_W-1:0] MAX_LIMIT =
        LEN_W'(MAX_REC_SEC * GRID_HZ * SAMPLES_PER_CYCLE);
    localparam int PCT_W       = 7;
    localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;

    // Record table and trigger selection
    localparam int TAB_DEPTH = 32;
    localparam int TAB_W     = 5;
    localparam int CNT_W     = 6;
    localparam int NUM_TRIG  = 8;
    localparam int SIG_W     = 16;
    localparam int SEL_W     = 4;
    localparam int ANA_CH    = 4;
    localparam int LANE_SEL  = 18;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_LIMIT    = 8'h04;
    localparam logic [7:0] OFF_LEAD     = 8'h08;
    localparam logic [7:0] OFF_TAIL     = 8'h0C;
    localparam logic [7:0] OFF_TRIG_SEL = 8'h10;
    localparam logic [7:0] OFF_TRIG_EN  = 8'h14;
    localparam logic [7:0] OFF_STATUS   = 8'h18;
    localparam logic [7:0] OFF_REC_SEL  = 8'h1C;
    localparam logic [7:0] OFF_REC_POS  = 8'h20;
    localparam logic [7:0] OFF_REC_LEN  = 8'h24;
    localparam logic [7:0] OFF_MEM_ADDR = 8'h28;
    localparam logic [7:0] OFF_MEM_DATA = 8'h2C;

    // Control bits
    localparam int CTRL_EN      = 0;
    localparam int CTRL_OVW     = 1;
    localparam int CTRL_MAN     = 2;
    localparam int CTRL_DEL_SEL = 3;
    localparam int CTRL_DEL_ALL = 4;

    // Status bits
    localparam int ST_BUSY   = 0;
    localparam int ST_LOCK   = 1;
    localparam int ST_FULL   = 2;
    localparam int ST_VALID  = 8;
    localparam int ST_ENTRY  = 16;

    // Reset values
    localparam logic [LEN_W-1:0] RST_LIMIT = 15'h0640;
    localparam logic [PCT_W-1:0] RST_LEAD  = 7'h14;
    localparam logic [PCT_W-1:0] RST_TAIL  = 7'h14;

    typedef struct packed {
        logic [SIG_W-1:0]             digital;
        logic [ANA_CH-1:0][15:0]      analog;
    } sample_t;

    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } avm_req_t;

    typedef enum logic [1:0] {
        REC_IDLE  = 2'b00,
        REC_EVENT = 2'b01,
        REC_TAIL  = 2'b10
    } rec_state_t;

endpackage : recorder_pkg

// ---- rtl/disturbance_recorder.sv ----
// Triggered waveform recorder: samples channels, keeps a circular history and
// stores records in a shared sample memory; registers over Avalon-MM.
// Assumes trigger sources and channel samples come from logic on core_clk.
`timescale 1ns/10ps
module disturbance_recorder
    import recorder_pkg::*;
#(
    parameter int SAMPLE_DIV = DEF_SAMPLE_DIV
) (
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire avm_req_t             avm_req,
    output logic [31:0]               avm_readdata,
    output logic                      avm_waitrequest,
    input  wire sample_t              sample_in,
    input  wire logic [SIG_W-1:0]     internal_sig,
    output logic                      rec_busy,
    output logic                      trig_lock,
    output logic                      store_full
);

    sample_t                  store_mem [STORE_DEPTH];
    logic [LEN_W-1:0]         tab_pos_len [TAB_DEPTH];
    logic [ADDR_W-1:0]        tab_start [TAB_DEPTH];
    logic [TAB_DEPTH-1:0]     tab_vld_ff;
    logic [TAB_W-1:0]         head_ff, tail_ff, rec_sel_ff;
    logic [CNT_W-1:0]         tab_cnt_ff, vcnt_ff;
    logic                     enable_ff, ovw_ff, man_ff, del_sel_ff, del_all_ff;
    logic [LEN_W-1:0]         limit_ff, lead_span_ff, tail_span_ff;
    logic [PCT_W-1:0]         lead_pct_ff, tail_pct_ff;
    logic [NUM_TRIG*SEL_W-1:0] trig_sel_ff;
    logic [NUM_TRIG-1:0]      trig_en_ff, trig_vec, cause_ff;
    logic [20:0]              mem_addr_ff;
    logic                     waitreq_ff, locked_ff, full_ff, busy_ff;
    logic [31:0]              readdata_ff, rd_mux;
    logic [DIV_W-1:0]         div_cnt_ff;
    logic                     tick_ff, pend_ff;
    sample_t                  pend_data_ff;
    sample_t                  buf_ff [2];
    logic                     buf_wsel_ff, buf_rsel_ff;
    logic [1:0]               buf_cnt_ff;
    logic [ADDR_W-1:0]        wr_ptr_ff, rec_start_ff;
    logic [LEN_W-1:0]         rec_len_ff, tail_cnt_ff, rec_limit_ff, rec_tail_ff;
    rec_state_t               state_ff;
    logic                     acc, wr_acc, trig_any, start, commit, push;
    logic                     buf_push, mem_we, mem_block, tab_pop;

    // Wrap the sample address at the storage depth
    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
        next_addr = (a == ADDR_W'(STORE_DEPTH - 1)) ? '0 : a + 1'b1;
    endfunction : next_addr

    // Table slot of the n-th oldest record
    function automatic logic [TAB_W-1:0] tab_idx(input logic [TAB_W-1:0] n);
        tab_idx = head_ff + n;
    endfunction : tab_idx

    assign acc    = (avm_req.read | avm_req.write) & waitreq_ff;
    assign wr_acc = acc & avm_req.write;

    // Bus answer one cycle after the request is seen
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            waitreq_ff  <= 1'b1;
            readdata_ff <= 32'h0000_0000;
        end else begin
            waitreq_ff <= ~acc;
            if (acc && avm_req.read) begin
                readdata_ff <= rd_mux;
            end
        end
    end

    // Read decode; unmapped offsets read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avm_req.address)
            OFF_CTRL:     rd_mux = {30'h0, ovw_ff, enable_ff};
            OFF_LIMIT:    rd_mux = {17'h0, limit_ff};
            OFF_LEAD:     rd_mux = {25'h0, lead_pct_ff};
            OFF_TAIL:     rd_mux = {25'h0, tail_pct_ff};
            OFF_TRIG_SEL: rd_mux = trig_sel_ff;
            OFF_TRIG_EN:  rd_mux = {24'h0, trig_en_ff};
            OFF_STATUS: begin
                rd_mux[ST_BUSY]              = busy_ff;
                rd_mux[ST_LOCK]              = locked_ff;
                rd_mux[ST_FULL]              = full_ff;
                rd_mux[ST_VALID +: CNT_W]    = vcnt_ff;
                rd_mux[ST_ENTRY +: CNT_W]    = tab_cnt_ff;
            end
            OFF_REC_SEL:  rd_mux = {27'h0, rec_sel_ff};
            OFF_REC_POS:  rd_mux = {13'h0, tab_vld_ff[tab_idx(rec_sel_ff)],
                                    tab_start[tab_idx(rec_sel_ff)]};
            OFF_REC_LEN:  rd_mux = {17'h0, tab_pos_len[tab_idx(rec_sel_ff)]};
            OFF_MEM_ADDR: rd_mux = {11'h0, mem_addr_ff};
            // 16-bit lane of one stored sample, lane 4 is the digital traces
            OFF_MEM_DATA: rd_mux = {16'h0, 16'(store_mem[mem_addr_ff[ADDR_W-1:0]]
                                    >> (16 * mem_addr_ff[LANE_SEL +: 3]))};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    // Configuration registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            enable_ff   <= 1'b0;
            ovw_ff      <= 1'b0;
            limit_ff    <= RST_LIMIT;
            lead_pct_ff <= RST_LEAD;
            tail_pct_ff <= RST_TAIL;
            trig_sel_ff <= '0;
            trig_en_ff  <= '0;
            rec_sel_ff  <= '0;
            mem_addr_ff <= '0;
        end else if (wr_acc) begin
            case (avm_req.address)
                OFF_CTRL: begin
                    enable_ff <= avm_req.writedata[CTRL_EN];
                    ovw_ff    <= avm_req.writedata[CTRL_OVW];
                end
                OFF_LIMIT: begin
                    if (avm_req.writedata > 32'(MAX_LIMIT)) begin
                        limit_ff <= MAX_LIMIT;
                    end else if (avm_req.writedata == 32'h0) begin
                        limit_ff <= 15'h0001;
                    end else begin
                        limit_ff <= avm_req.writedata[LEN_W-1:0];
                    end
                end
                OFF_LEAD: lead_pct_ff <= (avm_req.writedata > 32'(PCT_FULL)) ?
                                         PCT_FULL : avm_req.writedata[PCT_W-1:0];
                OFF_TAIL: tail_pct_ff <= (avm_req.writedata > 32'(PCT_FULL)) ?
                                         PCT_FULL : avm_req.writedata[PCT_W-1:0];
                OFF_TRIG_SEL: trig_sel_ff <= avm_req.writedata;
                OFF_TRIG_EN:  trig_en_ff  <= avm_req.writedata[NUM_TRIG-1:0];
                OFF_REC_SEL:  rec_sel_ff  <= avm_req.writedata[TAB_W-1:0];
                OFF_MEM_ADDR: mem_addr_ff <= avm_req.writedata[20:0];
                default: ;
            endcase
        end
    end

    // One-cycle command pulses from the control word
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            man_ff     <= 1'b0;
            del_sel_ff <= 1'b0;
            del_all_ff <= 1'b0;
        end else begin
            man_ff     <= wr_acc && avm_req.address == OFF_CTRL
                          && avm_req.writedata[CTRL_MAN];
            del_sel_ff <= wr_acc && avm_req.address == OFF_CTRL
                          && avm_req.writedata[CTRL_DEL_SEL];
            del_all_ff <= wr_acc && avm_req.address == OFF_CTRL
                          && avm_req.writedata[CTRL_DEL_ALL];
        end
    end

    // spans derived from percent of the limit
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lead_span_ff <= '0;
            tail_span_ff <= '0;
        end else begin
            lead_span_ff <= LEN_W'((32'(limit_ff) * 32'(lead_pct_ff)) / 32'(PCT_FULL));
            tail_span_ff <= LEN_W'((32'(limit_ff) * 32'(tail_pct_ff)) / 32'(PCT_FULL));
        end
    end

    // sample tick, 32 per power cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_cnt_ff <= '0;
            tick_ff    <= 1'b0;
        end else begin
            tick_ff    <= div_cnt_ff == DIV_W'(SAMPLE_DIV - 1);
            div_cnt_ff <= (div_cnt_ff == DIV_W'(SAMPLE_DIV - 1)) ? '0 : div_cnt_ff + 1'b1;
        end
    end

    // capture analog and digital channels together
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pend_ff      <= 1'b0;
            pend_data_ff <= '0;
        end else if (tick_ff) begin
            pend_ff      <= 1'b1;
            pend_data_ff <= sample_in;
        end else if (buf_push) begin
            pend_ff <= 1'b0;
        end
    end

    // Two-entry buffer; a halted writer backs up into the sampler
    assign buf_push = pend_ff && buf_cnt_ff != 2'h2;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            buf_wsel_ff <= 1'b0;
            buf_rsel_ff <= 1'b0;
            buf_cnt_ff  <= 2'h0;
        end else begin
            if (buf_push) begin
                buf_ff[buf_wsel_ff] <= pend_data_ff;
                buf_wsel_ff         <= ~buf_wsel_ff;
            end
            if (mem_we) begin
                buf_rsel_ff <= ~buf_rsel_ff;
            end
            buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_push} - {1'b0, mem_we};
        end
    end

    // Writer meets the oldest kept record after a full lap
    assign mem_block = tab_cnt_ff != '0 && tab_vld_ff[head_ff]
                       && wr_ptr_ff == tab_start[head_ff];
    assign mem_we = buf_cnt_ff != 2'h0 && !mem_block;

    // history written into the ring whenever a buffered sample waits and mem_block is low
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr_ff <= '0;
        end else if (mem_we) begin
            store_mem[wr_ptr_ff] <= buf_ff[buf_rsel_ff];
            wr_ptr_ff            <= next_addr(wr_ptr_ff);
        end
    end

    // each trigger input selects one internal signal
    for (genvar i = 0; i < NUM_TRIG; i++) begin : g_trig
        assign trig_vec[i] = trig_en_ff[i] & internal_sig[trig_sel_ff[i*SEL_W +: SEL_W]];
    end

    // inputs OR-linked; manual command joins them
    assign trig_any = |trig_vec;
    assign start    = state_ff == REC_IDLE && enable_ff && !locked_ff && !full_ff
                      && (trig_any || man_ff);

    // end at limit; tail ends at its span
    always_comb begin
        commit = 1'b0;
        case (state_ff)
            REC_EVENT: commit = rec_len_ff >= rec_limit_ff || full_ff;
            REC_TAIL:  commit = rec_len_ff >= rec_limit_ff || full_ff
                                || tail_cnt_ff >= rec_tail_ff;
            default:   commit = 1'b0;
        endcase
    end

    // Record sequence
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff     <= REC_IDLE;
            rec_len_ff   <= '0;
            tail_cnt_ff  <= '0;
            rec_start_ff <= '0;
            rec_limit_ff <= '0;
            rec_tail_ff  <= '0;
            cause_ff     <= '0;
        end else begin
            case (state_ff)
                REC_IDLE: begin
                    // start lead_in_span samples back in the ring
                    if (start) begin
                        state_ff     <= REC_EVENT;
                        rec_len_ff   <= lead_span_ff;
                        tail_cnt_ff  <= '0;
                        rec_limit_ff <= limit_ff;
                        rec_tail_ff  <= tail_span_ff;
                        cause_ff     <= trig_vec;
                        rec_start_ff <= (wr_ptr_ff >= ADDR_W'(lead_span_ff)) ?
                            wr_ptr_ff - ADDR_W'(lead_span_ff) :
                            ADDR_W'(STORE_DEPTH) + wr_ptr_ff - ADDR_W'(lead_span_ff);
                    end
                end
                REC_EVENT: begin
                    // event runs while the trigger stays active
                    if (commit) begin
                        state_ff <= REC_IDLE;
                    end else if (!trig_any) begin
                        state_ff <= REC_TAIL;
                    end
                    rec_len_ff <= rec_len_ff + LEN_W'(mem_we);
                end
                REC_TAIL: begin
                    if (commit) begin
                        state_ff <= REC_IDLE;
                    end
                    rec_len_ff  <= rec_len_ff + LEN_W'(mem_we);
                    tail_cnt_ff <= tail_cnt_ff + LEN_W'(mem_we);
                end
                default: state_ff <= REC_IDLE;
            endcase
        end
    end

    // lockout holds until every causing input drops
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            locked_ff <= 1'b0;
        end else if (commit) begin
            locked_ff <= 1'b1;
        end else if ((cause_ff & trig_vec) == '0) begin
            locked_ff <= 1'b0;
        end
    end

    // overwrite drops the oldest; empty records are not kept
    assign push    = commit && rec_len_ff != '0;
    assign tab_pop = tab_cnt_ff != '0 && (!tab_vld_ff[head_ff] || (ovw_ff && mem_block)
                     || (push && tab_cnt_ff == CNT_W'(TAB_DEPTH)));

    // variable number of records in a shared ring
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            head_ff    <= '0;
            tail_ff    <= '0;
            tab_cnt_ff <= '0;
            vcnt_ff    <= '0;
            tab_vld_ff <= '0;
        end else if (del_all_ff) begin
            head_ff    <= tail_ff;
            tab_cnt_ff <= '0;
            vcnt_ff    <= '0;
            tab_vld_ff <= '0;
        end else begin
            if (push) begin
                tab_start[tail_ff]   <= rec_start_ff;
                tab_pos_len[tail_ff] <= rec_len_ff;
                tab_vld_ff[tail_ff]  <= 1'b1;
                tail_ff              <= tail_ff + 1'b1;
            end
            if (tab_pop) begin
                head_ff <= head_ff + 1'b1;
            end
            if (del_sel_ff && CNT_W'(rec_sel_ff) < tab_cnt_ff) begin
                tab_vld_ff[tab_idx(rec_sel_ff)] <= 1'b0;
            end
            tab_cnt_ff <= tab_cnt_ff + CNT_W'(push) - CNT_W'(tab_pop);
            vcnt_ff    <= vcnt_ff + CNT_W'(push)
                          - CNT_W'(tab_pop && tab_vld_ff[head_ff])
                          - CNT_W'(del_sel_ff && CNT_W'(rec_sel_ff) < tab_cnt_ff
                                   && tab_vld_ff[tab_idx(rec_sel_ff)]
                                   && !(tab_pop && rec_sel_ff == '0));
        end
    end

    // stop mode: full until records are deleted
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            full_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            full_ff <= !ovw_ff && (mem_block || tab_cnt_ff == CNT_W'(TAB_DEPTH));
            busy_ff <= state_ff != REC_IDLE;
        end
    end

    assign avm_readdata    = readdata_ff;
    assign avm_waitrequest = waitreq_ff;
    assign rec_busy        = busy_ff;
    assign trig_lock       = locked_ff;
    assign store_full      = full_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_sample_period: assert property (tick_ff |-> $past(div_cnt_ff) == DIV_W'(SAMPLE_DIV - 1))
        else $error("sample tick off period");
    chk_trigger_or_start: assert property (start |=> state_ff == REC_EVENT)
        else $error("trigger did not start record");
    chk_lock_hold: assert property (locked_ff && (cause_ff & trig_vec) != '0 |=> !busy_ff)
        else $error("record started during lockout");
    chk_pre_length: assert property (start |=> rec_len_ff == $past(lead_span_ff))
        else $error("pre-trigger span wrong");
    chk_event_to_tail: assert property (state_ff == REC_EVENT && !trig_any && !commit
        |=> state_ff == REC_TAIL)
        else $error("event did not end with trigger");
    chk_tail_bound: assert property (state_ff == REC_TAIL |-> tail_cnt_ff <= rec_tail_ff)
        else $error("tail exceeded its span");
    chk_length_limit: assert property (state_ff != REC_IDLE |-> rec_len_ff <= rec_limit_ff)
        else $error("record longer than limit");
    chk_overwrite_pop: assert property (ovw_ff && mem_block && !del_all_ff
        |=> tab_cnt_ff == $past(tab_cnt_ff) - 1'b1 + CNT_W'($past(push)))
        else $error("oldest record not dropped");
    chk_stop_halt: assert property (!ovw_ff && mem_block |-> !mem_we ##1 full_ff)
        else $error("writer ran over stored record");
    chk_bus_answer: assert property (acc |=> !avm_waitrequest ##1 avm_waitrequest)
        else $error("bus answer not one cycle");

endmodule : disturbance_recorder

// ---- tb/protection_source.sv ----
// Stand-in for the protection logic: channel samples and internal signals.
// Assumes the bench seeds $urandom and commands which internal signals are up.
`timescale 1ns/10ps
module protection_source
    import recorder_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic [SIG_W-1:0] sig_cmd,
    output sample_t               sample_out,
    output logic      [SIG_W-1:0] sig_out
);
    // New channel values every cycle so stale history never looks valid
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sample_out <= '0;
            sig_out    <= '0;
        end else begin
            sample_out <= {16'($urandom), $urandom, $urandom};
            sig_out    <= sig_cmd; // Registered, like real protection outputs
        end
    end
endmodule : protection_source

// ---- tb/disturbance_waveform_recorder_tb.sv ----
// Self-checking bench for the recorder: register bus, triggers, records.
// Assumes SAMPLE_DIV of 8 so that a 100 sample record stays short.
`timescale 1ns/10ps
module disturbance_waveform_recorder_tb;
    import recorder_pkg::*;
    logic             core_clk = 1'b0;
    logic             sys_rst  = 1'b1;
    avm_req_t         req      = '0;
    logic [31:0]      rdata;
    logic             waitreq, rec_busy, trig_lock, store_full;
    sample_t          smp;
    logic [SIG_W-1:0] sig, sig_cmd = '0;
    logic [31:0]      q;
    int               error_cnt = 0, checks_done = 0, v, lim_m = 100, lead_m = 20;

    always #2 core_clk = ~core_clk;

    disturbance_recorder #(.SAMPLE_DIV(8)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .avm_req(req), .avm_readdata(rdata), .avm_waitrequest(waitreq), .sample_in(smp),
        .internal_sig(sig), .rec_busy(rec_busy), .trig_lock(trig_lock),
        .store_full(store_full));
    protection_source src (.core_clk(core_clk), .sys_rst(sys_rst), .sig_cmd(sig_cmd),
        .sample_out(smp), .sig_out(sig));

    task complete_run;
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Hold the request until waitrequest is sampled low, then release
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req.address   <= a;
        req.read      <= !wr;
        req.write     <= wr;
        req.writedata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 100);
        if (n >= 100) error_cnt++;
        q = rdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    // Bounded wait for busy (sel 0) or lock (sel 1) to reach a level
    task wait_lvl(input int sel, input logic lvl);
        int n;
        for (n = 0; n < 5000 && (sel ? trig_lock : rec_busy) !== lvl; n++)
            @(posedge core_clk);
        if (n >= 5000) error_cnt++;
    endtask : wait_lvl

    initial begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h3F421C80));
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        bus(0, OFF_LIMIT, 0); check("limit rst", q, 32'h0000_0640);
        bus(0, OFF_LEAD, 0);  check("lead rst", q, 32'h0000_0014);
        bus(0, 8'h30, 0);     check("unmapped", q, 32'h0000_0000);
        bus(1, OFF_LIMIT, 32'h0000_7530);
        bus(0, OFF_LIMIT, 0); check("limit clamp", q, 32'h0000_5DC0);
        // Percent settings beyond full scale saturate at 100
        repeat (4) begin
            v = $urandom_range(0, 127);
            bus(1, OFF_TAIL, v);
            bus(0, OFF_TAIL, 0); check("tail pct", q, (v > 100) ? 100 : v);
        end
        bus(1, OFF_LIMIT, lim_m);
        bus(1, OFF_LEAD, lead_m);
        bus(1, OFF_TAIL, 30);
        bus(1, OFF_TRIG_SEL, 32'h0090_0003);
        bus(1, OFF_TRIG_EN, 32'h0000_0021);
        bus(1, OFF_CTRL, 32'h0000_0001);
        // Trigger outlasts the limit, through either OR-ed input
        for (int k = 0; k < 2; k++) begin
            sig_cmd <= k ? 16'h0200 : 16'h0008;
            wait_lvl(0, 1'b1);
            wait_lvl(0, 1'b0);
            repeat (40) @(posedge core_clk);
            check("lock", trig_lock, 1'b1);
            check("no restart", rec_busy, 1'b0);
            bus(0, OFF_STATUS, 0);  check("count", q[13:8], k + 1);
            bus(1, OFF_REC_SEL, k);
            bus(0, OFF_REC_LEN, 0); check("rec len", q, lim_m);
            bus(0, OFF_REC_POS, 0); check("pos valid", q[18], 1'b1);
            sig_cmd <= '0;
            wait_lvl(1, 1'b0);
            check("unlock", trig_lock, 1'b0);
        end
        // Manual start: lead-in, at most one event sample, then tail
        bus(1, OFF_CTRL, 32'h0000_0005);
        wait_lvl(0, 1'b1);
        wait_lvl(0, 1'b0);
        bus(0, OFF_STATUS, 0);  check("manual", q[13:8], 3);
        bus(1, OFF_REC_SEL, 2);
        bus(0, OFF_REC_LEN, 0);
        check("man len", q == lim_m * lead_m / 100 + 30 || q == 51, 1'b1);
        check("not full", store_full, 1'b0);
        // Delete the middle record only; its table entry stays until oldest
        bus(1, OFF_REC_SEL, 1);
        bus(1, OFF_CTRL, 32'h0000_0009);
        bus(0, OFF_STATUS, 0);  check("del sel", q[13:8], 2);
        check("entries", q[21:16], 3);
        bus(1, OFF_CTRL, 32'h0000_0011);
        bus(0, OFF_STATUS, 0);  check("del all", q[13:8], 0);
        complete_run();
    end
endmodule : disturbance_waveform_recorder_tb
